// >>> brx_exec.sv
// Functional notes
// - Branch-if-no-overflow branches only with overflow clear, no flag change.
// - Branch-if-nonzero branches only with zero clear, no flag change.
// - A taken branch loads PC with PC plus 2 plus twice the signed offset.
// - Branch takes one cycle untaken, two taken with a following idle cycle.
// - Rotate right through carry moves bit 0 to carry, carry to bit 7.
// - Destination bit 0 writes the working register, 1 the file register.
// - Access bit 0 selects the access bank, 1 uses the bank select register.
// - Extended set with access bit 0 makes addresses up to 95 indexed.
// - Sleep clears powerdown, sets timeout, clears watchdog and sleeps, all on the same edge.
`include "brx_cfg.svh"
`default_nettype none
module brx_exec (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic q4_i,
    input wire logic ins_valid_i,
    input wire logic [15:0] ins_i,
    input wire brx_pkg::brx_pc_t pc_i,
    input wire logic ext_set_i,
    input wire logic [3:0] bank_select_register_i,
    input wire logic [7:0] fsr2_i,
    input wire logic [7:0] fdata_i,
    input wire logic wake_i,
    output logic [11:0] faddr_o,
    output logic [7:0] fwdata_o,
    output logic fwe_o,
    output logic [7:0] wreg_o,
    output logic carry_o,
    output logic digit_carry_o,
    output logic overflow_flag_o,
    output logic negative_o,
    output logic zero_o,
    output logic timeout_flag_o,
    output logic powerdown_flag_o,
    output logic watchdog_timer_clr_o,
    output logic sleep_o,
    output logic pc_load_o,
    output brx_pkg::brx_pc_t pc_next_o,
    output logic stall_o
);
    import brx_pkg::*;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic flush;
    brx_op_e op;
    wire [15:0] bno_pat = `BRX_OP_BNO;
    wire [15:0] bnz_pat = `BRX_OP_BNZR;
    wire [7:0] hi = ins_i[15:8];
    wire is_bov = (hi == bno_pat[15:8]);
    wire is_bnz = (hi == bnz_pat[15:8]);
    wire [5:0] fam = ins_i[15:10];
    wire d_bit = ins_i[`BRX_DBIT];
    wire a_bit = ins_i[`BRX_ABIT];
    wire [7:0] f_lit = ins_i[7:0];

    always_comb begin
        op = BRX_NONE;
        if (is_bov)
            op = BRX_BOV;
        else if (is_bnz)
            op = BRX_BNZ;
        else if (ins_i == `BRX_OP_SLP)
            op = BRX_SLP;
        else if (fam == `BRX_OP_RRC)
            op = BRX_RRC;
        else if (fam == `BRX_OP_RLP)
            op = BRX_RLP;
        else if (fam == `BRX_OP_SBB)
            op = BRX_SBB;
    end

    wire act = ins_valid_i && q4_i && !flush && !sleep_o;

    // ------------------------------------------------------------------
    // File address
    // ------------------------------------------------------------------
    wire indexed = ext_set_i && !a_bit && (f_lit <= `BRX_IDX_LIMIT);
    wire [7:0] idx_addr = fsr2_i + f_lit;
    wire [3:0] acc_bank = (f_lit < `BRX_ACC_SPLIT) ? 4'h0 : 4'hF;
    assign faddr_o = indexed ? {4'h0, idx_addr} :
        a_bit ? {bank_select_register_i, f_lit} :
        {acc_bank, f_lit};

    // ------------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------------
    logic [7:0] res;
    logic c_n, dc_n, ov_n, n_n, z_n;
    brx_alu u_alu (
        .op_i(op),
        .wreg_i(wreg_o),
        .freg_i(fdata_i),
        .carry_i(carry_o),
        .result_o(res),
        .carry_o(c_n),
        .dc_o(dc_n),
        .ov_o(ov_n),
        .neg_o(n_n),
        .zero_o(z_n)
    );

    wire file_op = (op == BRX_RRC) || (op == BRX_RLP) || (op == BRX_SBB);
    wire take = ((op == BRX_BOV) && !overflow_flag_o)
        || ((op == BRX_BNZ) && !zero_o);
    wire [20:0] offs = {{12{f_lit[7]}}, f_lit, 1'b0};

    assign fwdata_o = res;
    assign fwe_o = act && file_op && d_bit;
    assign pc_load_o = act && take;
    assign pc_next_o = pc_i + `BRX_PC_STEP + offs;
    assign stall_o = flush;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flush <= 1'b0;
        end else if (q4_i) begin
            flush <= act && take;
        end
    end

    // Branches deliberately skip this block, so status stays untouched.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wreg_o <= 8'h00;
            carry_o <= 1'b0;
            digit_carry_o <= 1'b0;
            overflow_flag_o <= 1'b0;
            negative_o <= 1'b0;
            zero_o <= 1'b0;
        end else if (act && file_op) begin
            if (!d_bit)
                wreg_o <= res;
            negative_o <= n_n;
            zero_o <= z_n;
            if (op != BRX_RLP)
                carry_o <= c_n;
            if (op == BRX_SBB) begin
                digit_carry_o <= dc_n;
                overflow_flag_o <= ov_n;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timeout_flag_o <= 1'b1;
            powerdown_flag_o <= 1'b1;
            watchdog_timer_clr_o <= 1'b0;
            sleep_o <= 1'b0;
        end else begin
            watchdog_timer_clr_o <= act && (op == BRX_SLP);
            if (act && (op == BRX_SLP)) begin
                timeout_flag_o <= 1'b1;
                powerdown_flag_o <= 1'b0;
                sleep_o <= 1'b1;
            end else if (wake_i) begin
                sleep_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> brx_cfg.svh
`ifndef BRX_CFG_SVH
`define BRX_CFG_SVH

// ----------------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------------
`define BRX_OP_BNO 16'hE5_00
`define BRX_OP_BNZR 16'hE1_00
`define BRX_OP_SLP 16'h0003
`define BRX_OP_RRC 6'h0C
`define BRX_OP_RLP 6'h11
`define BRX_OP_SBB 6'h15
`define BRX_IDX_LIMIT 8'h5F
`define BRX_DBIT 9
`define BRX_ABIT 8
`define BRX_PC_STEP 21'h00_0002
`define BRX_ACC_SPLIT 8'h80

`endif

// >>> brx_pkg.sv
`default_nettype none
package brx_pkg;
    typedef enum logic [2:0] {
        BRX_NONE = 3'b000,
        BRX_BOV = 3'b001,
        BRX_BNZ = 3'b010,
        BRX_RRC = 3'b011,
        BRX_RLP = 3'b100,
        BRX_SBB = 3'b101,
        BRX_SLP = 3'b110
    } brx_op_e;
    typedef logic [20:0] brx_pc_t;
endpackage
`default_nettype wire

// >>> brx_alu.sv
`include "brx_cfg.svh"
`default_nettype none
module brx_alu (
    input wire brx_pkg::brx_op_e op_i,
    input wire logic [7:0] wreg_i,
    input wire logic [7:0] freg_i,
    input wire logic carry_i,
    output logic [7:0] result_o,
    output logic carry_o,
    output logic dc_o,
    output logic ov_o,
    output logic neg_o,
    output logic zero_o
);
    import brx_pkg::*;

    wire [8:0] sub_full = {1'b0, wreg_i} + {1'b0, ~freg_i}
        + {8'h00, carry_i};
    wire [4:0] sub_low = {1'b0, wreg_i[3:0]} + {1'b0, ~freg_i[3:0]}
        + {4'h0, carry_i};
    wire [7:0] rrc_res = {carry_i, freg_i[7:1]};
    wire [7:0] rlp_res = {freg_i[6:0], freg_i[7]};

    // Carry here is not-borrow, so carry set means no borrow occurred.
    always_comb begin
        result_o = freg_i;
        carry_o = carry_i;
        dc_o = 1'b0;
        ov_o = 1'b0;
        unique case (op_i)
            BRX_RRC: begin
                result_o = rrc_res;
                carry_o = freg_i[0];
            end
            BRX_RLP: result_o = rlp_res;
            BRX_SBB: begin
                result_o = sub_full[7:0];
                carry_o = sub_full[8];
                dc_o = sub_low[4];
                ov_o = (wreg_i[7] != freg_i[7])
                    && (sub_full[7] != wreg_i[7]);
            end
            default: result_o = freg_i;
        endcase
    end
    assign neg_o = result_o[7];
    assign zero_o = (result_o == 8'h00);
endmodule
`default_nettype wire

// >>> brx_exec_assertions.sv
`include "brx_cfg.svh"
`default_nettype none
module brx_exec_assertions (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic q4_i,
    input wire logic ins_valid_i,
    input wire logic [15:0] ins_i,
    input wire brx_pkg::brx_pc_t pc_i,
    input wire logic [3:0] bank_select_register_i,
    input wire logic [7:0] fdata_i,
    input wire logic [11:0] faddr_o,
    input wire logic [7:0] fwdata_o,
    input wire logic fwe_o,
    input wire logic carry_o,
    input wire logic overflow_flag_o,
    input wire logic zero_o,
    input wire logic timeout_flag_o,
    input wire logic powerdown_flag_o,
    input wire logic watchdog_timer_clr_o,
    input wire logic sleep_o,
    input wire logic pc_load_o,
    input wire brx_pkg::brx_pc_t pc_next_o,
    input wire logic stall_o
);
    import brx_pkg::*;
    wire logic go = q4_i && ins_valid_i && !stall_o && !sleep_o;
    wire logic [7:0] hi = ins_i[15:8];
    wire logic [5:0] op6 = ins_i[15:10];
    wire logic alu = go && (op6 == `BRX_OP_RRC || op6 == `BRX_OP_RLP
        || op6 == `BRX_OP_SBB);
    wire logic [20:0] tgt = pc_i + `BRX_PC_STEP
        + {{12{ins_i[7]}}, ins_i[7:0], 1'b0};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    nz_taken_a: assert property (go && hi == 8'hE1 && !zero_o |->
        pc_load_o && pc_next_o == tgt) else $error("nonzero branch");
    nz_held_a: assert property (go && hi == 8'hE1 && zero_o |->
        !pc_load_o ##1 !stall_o) else $error("nonzero branch held");
    nov_taken_a: assert property (go && hi == 8'hE5 && !overflow_flag_o
        |-> pc_load_o && pc_next_o == tgt) else $error("overflow branch");
    br_flags_a: assert property (go && (hi == 8'hE1 || hi == 8'hE5)
        |=> $stable({carry_o, overflow_flag_o, zero_o})) else $error("flags");
    stall_gap_a: assert property (go && pc_load_o |=>
        stall_o ##[1:5] !stall_o) else $error("stall length");
    dest_bit_a: assert property (alu |-> fwe_o == ins_i[`BRX_DBIT])
        else $error("destination");
    bank_sel_a: assert property (alu && ins_i[`BRX_ABIT] |->
        faddr_o == {bank_select_register_i, ins_i[7:0]}) else $error("bank");
    rot_left_a: assert property (alu && op6 == `BRX_OP_RLP && ins_i[9]
        |-> fwdata_o == {fdata_i[6:0], fdata_i[7]} ##1 $stable(carry_o))
        else $error("rotate left");
    rot_right_a: assert property (alu && op6 == `BRX_OP_RRC && ins_i[9]
        |-> fwdata_o == {carry_o, fdata_i[7:1]}) else $error("rotate right");
    sleep_fx_a: assert property (go && ins_i == `BRX_OP_SLP |=> sleep_o
        && timeout_flag_o && !powerdown_flag_o && watchdog_timer_clr_o)
        else $error("sleep");
    cover property (go && pc_load_o);
    cover property (alu && fwe_o);
    cover property (sleep_o);
endmodule
bind brx_exec brx_exec_assertions u_brx_exec_assertions (.*);
`default_nettype wire

// >>> brx_exec_tb.sv
`include "brx_cfg.svh"
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    miscompares++; $display("Error %s exp %0h got %0h", n, e, s); end end
module brx_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import brx_pkg::*;
    logic clk_i = 0, rst_n_i = 0, q4_i = 0, ins_valid_i = 0;
    logic ext_set_i = 0, wake_i = 0, fwe_o, carry_o, digit_carry_o;
    logic overflow_flag_o, negative_o, zero_o, timeout_flag_o, stall_o;
    logic powerdown_flag_o, watchdog_timer_clr_o, sleep_o, pc_load_o;
    logic [15:0] ins_i = 0;
    logic [3:0] bank_select_register_i = 0;
    logic [7:0] fsr2_i = 0, fdata_i = 0, fwdata_o, wreg_o, w = 0, r;
    logic [11:0] faddr_o, ea;
    brx_pc_t pc_i = 0, pc_next_o;
    logic c = 0, z = 0, v = 0, stl = 0, n = 0, dc = 0;
    int miscompares = 0, cmp_count = 0;
    logic [23:0] cn [8] = '{24'hE1_8000, 24'hE1_7F00, 24'h44_0000,
        24'hE1_0500, 24'h31_60A5, 24'h54_5F80, 24'hE5_1000, 24'h00_0300};
    logic [15:0] base [6] = '{`BRX_OP_BNZR, `BRX_OP_BNO, 16'h3000,
        16'h4400, 16'h5400, `BRX_OP_SLP};
    brx_exec u_brx_exec (.*);
    always #50 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // One instruction on a q4 slot, checked against a shadow core
    // ------------------------------------------------------------
    task automatic issue(input logic [15:0] op, input logic [7:0] fd);
        logic [8:0] s;
        logic alu, tk, ix, dr;
        logic [4:0] sl;
        brx_pc_t p;
        p = 21'($urandom) << 1;
        @(posedge clk_i);
        {ins_i, fdata_i, pc_i, q4_i, ins_valid_i} <= {op, fd, p, 2'b11};
        {ext_set_i, bank_select_register_i, fsr2_i} <= 13'($urandom);
        #50;
        alu = op[15:10] inside {`BRX_OP_RRC, `BRX_OP_RLP, `BRX_OP_SBB};
        tk = (op[15:8] == 8'hE1 && !z) || (op[15:8] == 8'hE5 && !v);
        s = {1'b0, w} + {1'b0, ~fd} + 9'(c);
        sl = {1'b0, w[3:0]} + {1'b0, ~fd[3:0]} + 5'(c);
        r = op[15:10] == `BRX_OP_RRC ? {c, fd[7:1]} :
            op[15:10] == `BRX_OP_RLP ? {fd[6:0], fd[7]} : s[7:0];
        ix = ext_set_i && !op[8] && op[7:0] <= `BRX_IDX_LIMIT;
        ea = op[8] ? {bank_select_register_i, op[7:0]} :
            ix ? {4'h0, fsr2_i + op[7:0]} : {{4{op[7]}}, op[7:0]};
        dr = stl;
        if (stl) begin
            `CHK("drop", 1'b0, pc_load_o | fwe_o)
            {alu, tk, stl} = 3'b000;
        end else begin
            `CHK("load", tk, pc_load_o)
            if (tk) `CHK("target", p + 21'd2 +
                21'(signed'(op[7:0]) * 2), pc_next_o)
            if (alu) `CHK("fwe", op[9], fwe_o)
            if (alu && op[9]) `CHK("fdata", r, fwdata_o)
            if (alu) `CHK("addr", ea, faddr_o)
        end
        if (alu && op[15:10] == `BRX_OP_SBB) v = (w[7] != fd[7]) && (r[7] != w[7]);
        if (alu && op[15:10] == `BRX_OP_SBB) dc = sl[4];
        if (alu) n = r[7];
        if (alu && op[15:10] != `BRX_OP_RLP) c = op[10] ? s[8] : fd[0];
        if (alu && !op[9]) w = r;
        if (alu) z = r == 8'h00;
        @(posedge clk_i);
        {q4_i, ins_valid_i} <= 2'b00;
        #50;
        `CHK("flags", {w, c, z, v, tk}, {wreg_o, carry_o, zero_o, overflow_flag_o, stall_o})
        `CHK("nd", {n, dc}, {negative_o, digit_carry_o})
        stl = tk;
        if (op == `BRX_OP_SLP && !dr) begin
            `CHK("sleep", 4'hD, {sleep_o, timeout_flag_o, powerdown_flag_o, watchdog_timer_clr_o})
            @(posedge clk_i) wake_i <= 1'b1;
            @(posedge clk_i) wake_i <= 1'b0;
        end
        repeat (2) @(posedge clk_i);
    endtask
    task automatic results();
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Corner cases first, since random data rarely sets zero or overflow
    // ------------------------------------------------------------
    initial begin
        int k;
        void'($urandom(32'hdfc242d3));
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        foreach (cn[i]) issue(cn[i][23:8], cn[i][7:0]);
        repeat (300) begin
            k = $urandom % 6;
            issue(base[k] | (k < 2 ? 16'($urandom % 256) : k < 5 ?
                16'($urandom % 1024) : 16'h0000), 8'($urandom));
        end
        results();
    end
    initial begin
        #1_000_000;
        miscompares++;
        results();
    end
endmodule
`default_nettype wire
